// [ddrsq_ctrl.sv]
// controller side of ddr4 reset, zq calibration and self-refresh spacing
// assumes the requester holds a request until acked and keeps i_cfg static
//
// Overview of operation
// R1 - after reset the first zq long calibration blocks every command for 1024 clocks.
// R2 - a zq long calibration in normal operation blocks every command for 512 clocks.
// R3 - a zq short calibration blocks every command for 128 clocks.
// R4 - after reset release and cke high no command goes out before max(5 clocks, tRFC+10ns).
// R5 - after self-refresh exit commands without a locked dll wait tRFC+10ns.
// R6 - with self-refresh abort on, those commands wait only tRFC4+10ns.
// R7 - zq calibration and fast mode writes after self-refresh exit wait tRFC4+10ns.
// R8 - commands needing a locked dll wait the dll lock time after self-refresh exit.
// R9 - cke stays low from self-refresh entry to exit for at least tCKE plus one clock.
// R10 - with parity on, that least cke low time grows by the parity latency.
// R11 - with parity on, the clock runs max(5 clocks, 10ns) plus parity latency after entry.
// R12 - each absolute time is rounded up to clocks; the tRFC based ones are held by a blocking down-counter, the 10ns clock time by the cke low count.
`timescale 1ns/1ps
`include "ddrsq_map.svh"
`default_nettype none
module ddrsq_ctrl
    import ddrsq_pkg::*;
#(
    parameter int TRFC_NS = `DDRSQ_TRFC_NS,
    parameter int TRFC4_NS = `DDRSQ_TRFC4_NS,
    parameter int TDLLK_NCK = `DDRSQ_TDLLK_NCK,
    parameter int TCKE_NCK = `DDRSQ_TCKE_NCK,
    parameter int RST_HOLD_NCK = `DDRSQ_RST_HOLD_NCK
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire ddrsq_cmd_t i_req,
    input wire ddrsq_cfg_t i_cfg,
    output logic o_ack,
    output ddrsq_cmd_t o_cmd,
    output logic o_cke,
    output logic o_dram_rst_n,
    output logic o_ck_en,
    output logic o_init_done
);
    localparam int ZQINIT_C = `DDRSQ_ZQINIT_NCK;
    localparam int ZQOPER_C = `DDRSQ_ZQOPER_NCK;
    localparam int ZQCS_C = `DDRSQ_ZQCS_NCK;
    localparam int XPR_C = max2(`DDRSQ_XPR_MIN_NCK, ns_to_cyc(TRFC_NS + `DDRSQ_XS_EXTRA_NS)); // R12
    localparam int XS_C = ns_to_cyc(TRFC_NS + `DDRSQ_XS_EXTRA_NS); // R12
    localparam int XS_FAST_C = ns_to_cyc(TRFC4_NS + `DDRSQ_XS_EXTRA_NS); // R12
    localparam int CKSRE_C = max2(`DDRSQ_CKSRE_MIN_NCK, ns_to_cyc(`DDRSQ_CKSRE_NS)); // R12
    localparam int CKESR_C = TCKE_NCK + `DDRSQ_CKESR_EXTRA_NCK;
    localparam int CNT_MAX = (1 << `DDRSQ_CNT_W) - 2;

    if (XPR_C > CNT_MAX || XS_C > CNT_MAX || XS_FAST_C > CNT_MAX || TDLLK_NCK > CNT_MAX
        || RST_HOLD_NCK > CNT_MAX || TCKE_NCK < 1) begin : g_bad_param
        $error("ddrsq_ctrl: timing parameter out of range of the counters");
    end

    ddrsq_ctrl_t r_reg;
    ddrsq_ctrl_t r_next;
    logic [`DDRSQ_T_NUM-1:0] t_load;
    logic [`DDRSQ_CNT_W-1:0] t_val [`DDRSQ_T_NUM];
    logic [`DDRSQ_T_NUM-1:0] t_busy;
    logic [`DDRSQ_CNT_W-1:0] pl_add;
    logic [`DDRSQ_CNT_W-1:0] ckesr_req;
    logic [`DDRSQ_CNT_W-1:0] cksre_req;
    logic req_ok;

    for (genvar g = 0; g < `DDRSQ_T_NUM; g++) begin : g_tmr
        ddrsq_timer u_tmr (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_load(t_load[g]),
            .i_val(t_val[g]),
            .o_busy(t_busy[g])
        );
    end

    // parity adds its latency to the cke low and clock valid windows
    always_comb begin
        pl_add = i_cfg.par_en ? `DDRSQ_CNT_W'(i_cfg.par_lat) : '0;
        ckesr_req = `DDRSQ_CNT_W'(CKESR_C) + pl_add; // R9 R10
        cksre_req = `DDRSQ_CNT_W'(CKSRE_C) + pl_add; // R11
    end

    // which command class the timers currently let through
    always_comb begin
        req_ok = 1'b0;
        if (i_req.valid && !t_busy[`DDRSQ_T_ALL]) begin // R1 R2 R3 R4
            unique case (i_req.op)
                op_plain: req_ok = !t_busy[`DDRSQ_T_NODLL]; // R5 R6
                op_zq_long, op_zq_short, op_mrs_fast: req_ok = !t_busy[`DDRSQ_T_FAST]; // R7
                op_dll_rd: req_ok = !t_busy[`DDRSQ_T_DLL]; // R8
                op_sre: req_ok = 1'b1;
                op_nop, op_srx: req_ok = 1'b0;
            endcase
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.cmd = '0;
        r_next.cmd_init = 1'b0;
        t_load = '0;
        for (int i = 0; i < `DDRSQ_T_NUM; i++) begin
            t_val[i] = '0;
        end
        unique case (r_reg.st)
            st_rst_hold: begin
                if (r_reg.cnt == '0) begin
                    r_next.rst_n = 1'b1;
                    r_next.cke = 1'b1;
                    t_load[`DDRSQ_T_ALL] = 1'b1;
                    t_val[`DDRSQ_T_ALL] = `DDRSQ_CNT_W'(XPR_C); // R4
                    r_next.st = st_zq_init;
                end else begin
                    r_next.cnt = r_reg.cnt - `DDRSQ_CNT_W'(1);
                end
            end
            st_zq_init: begin
                if (!t_busy[`DDRSQ_T_ALL]) begin
                    r_next.cmd = '{valid: 1'b1, op: op_zq_long};
                    r_next.cmd_init = 1'b1;
                    t_load[`DDRSQ_T_ALL] = 1'b1;
                    t_val[`DDRSQ_T_ALL] = `DDRSQ_CNT_W'(ZQINIT_C); // R1
                    r_next.done = 1'b1;
                    r_next.st = st_idle;
                end
            end
            st_idle: begin
                if (req_ok) begin
                    r_next.cmd = i_req;
                    r_next.ack = 1'b1;
                    if (i_req.op == op_zq_long) begin
                        t_load[`DDRSQ_T_ALL] = 1'b1;
                        t_val[`DDRSQ_T_ALL] = `DDRSQ_CNT_W'(ZQOPER_C); // R2
                    end else if (i_req.op == op_zq_short) begin
                        t_load[`DDRSQ_T_ALL] = 1'b1;
                        t_val[`DDRSQ_T_ALL] = `DDRSQ_CNT_W'(ZQCS_C); // R3
                    end else if (i_req.op == op_sre) begin
                        r_next.cke = 1'b0;
                        r_next.st = st_sr_clk;
                    end
                end
            end
            st_sr_clk: begin
                if (r_reg.low >= cksre_req) begin // R11
                    r_next.ck_en = 1'b0;
                    r_next.st = st_sr_low;
                end
            end
            st_sr_low: begin
                // the exit request waits unacked until cke has been low long enough
                if (i_req.valid && i_req.op == op_srx && r_reg.low >= ckesr_req) begin // R9 R10
                    r_next.ck_en = 1'b1;
                    r_next.cnt = cksre_req;
                    r_next.st = st_sr_wake;
                end
            end
            st_sr_wake: begin
                if (r_reg.cnt == '0) begin
                    r_next.cke = 1'b1;
                    r_next.cmd = '{valid: 1'b1, op: op_srx};
                    r_next.ack = 1'b1;
                    t_load[`DDRSQ_T_NODLL] = 1'b1;
                    t_val[`DDRSQ_T_NODLL] = i_cfg.abort_en ? `DDRSQ_CNT_W'(XS_FAST_C)
                                                          : `DDRSQ_CNT_W'(XS_C); // R5 R6
                    t_load[`DDRSQ_T_FAST] = 1'b1;
                    t_val[`DDRSQ_T_FAST] = `DDRSQ_CNT_W'(XS_FAST_C); // R7
                    t_load[`DDRSQ_T_DLL] = 1'b1;
                    t_val[`DDRSQ_T_DLL] = `DDRSQ_CNT_W'(TDLLK_NCK); // R8
                    r_next.st = st_idle;
                end else begin
                    r_next.cnt = r_reg.cnt - `DDRSQ_CNT_W'(1);
                end
            end
        endcase
        r_next.low = r_next.cke ? '0 : inc_sat(r_reg.low);
        r_next.gap = r_reg.cmd.valid ? `DDRSQ_CNT_W'(1) : inc_sat(r_reg.gap);
        r_next.last_op = r_reg.cmd.valid ? r_reg.cmd.op : r_reg.last_op;
        r_next.prev_init = r_reg.cmd.valid ? r_reg.cmd_init : r_reg.prev_init;
        r_next.since_srx = (r_reg.cmd.valid && r_reg.cmd.op == op_srx) ? `DDRSQ_CNT_W'(1)
                                                                         : inc_sat(r_reg.since_srx);
        r_next.since_rise = (r_reg.st == st_rst_hold) ? '0 : inc_sat(r_reg.since_rise);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r_reg <= '0;
            r_reg.cnt <= `DDRSQ_CNT_W'(RST_HOLD_NCK);
            r_reg.since_srx <= '1;
            r_reg.ck_en <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_ack = r_reg.ack;
    assign o_cmd = r_reg.cmd;
    assign o_cke = r_reg.cke;
    assign o_dram_rst_n = r_reg.rst_n;
    assign o_ck_en = r_reg.ck_en;
    assign o_init_done = r_reg.done;

    chk_zq_init_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
        o_cmd.valid && r_reg.prev_init |-> r_reg.gap >= ZQINIT_C)
        else $error("command inside initial zq calibration");
    chk_zq_long_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R2
        o_cmd.valid && r_reg.last_op == op_zq_long && !r_reg.prev_init
        |-> r_reg.gap >= ZQOPER_C)
        else $error("command inside zq long calibration");
    chk_zq_short_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
        o_cmd.valid && r_reg.last_op == op_zq_short |-> r_reg.gap >= ZQCS_C)
        else $error("command inside zq short calibration");
    chk_reset_exit_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R4
        o_cmd.valid |-> (o_cke != (o_cmd.op == op_sre)) && r_reg.since_rise >= XPR_C)
        else $error("command before reset exit time");
    chk_srx_nodll_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
        o_cmd.valid && o_cmd.op == op_plain && !i_cfg.abort_en |-> r_reg.since_srx >= XS_C)
        else $error("plain command too soon after self-refresh exit");
    chk_srx_abort_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
        o_cmd.valid && o_cmd.op == op_plain && i_cfg.abort_en
        |-> r_reg.since_srx >= XS_FAST_C)
        else $error("plain command too soon after aborted self-refresh");
    chk_srx_fast_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R7
        o_cmd.valid && (o_cmd.op inside {op_zq_long, op_zq_short, op_mrs_fast})
        |-> r_reg.since_srx >= XS_FAST_C)
        else $error("zq or fast mode write too soon after self-refresh exit");
    chk_srx_dll_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
        o_cmd.valid && o_cmd.op == op_dll_rd |-> r_reg.since_srx >= TDLLK_NCK)
        else $error("dll command before dll lock time");
    chk_cke_low_width: assert property (@(posedge i_clk) disable iff (!i_nrst) // R9
        $rose(o_cke) && o_cmd.op == op_srx && !i_cfg.par_en |-> $past(r_reg.low) >= CKESR_C)
        else $error("cke low too short in self-refresh");
    chk_cke_low_par: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
        $rose(o_cke) && o_cmd.op == op_srx && i_cfg.par_en
        |-> $past(r_reg.low) >= CKESR_C + int'(i_cfg.par_lat))
        else $error("cke low too short in self-refresh with parity");
    chk_clock_after_sre: assert property (@(posedge i_clk) disable iff (!i_nrst) // R11
        $fell(o_ck_en) && i_cfg.par_en |-> !o_cke && $past(r_reg.low) >= CKSRE_C
        + int'(i_cfg.par_lat))
        else $error("clock stopped too soon after self-refresh entry");
endmodule
`default_nettype wire

// [ddrsq_map.svh]
// constants of the ddr4 reset, self-refresh and zq command sequencer
// assumes a 250 MHz controller clock that also drives the memory clock
`ifndef DDRSQ_MAP_SVH
`define DDRSQ_MAP_SVH
`define DDRSQ_CLK_PS 4000
`define DDRSQ_CNT_W 16
`define DDRSQ_PL_W 4
`define DDRSQ_ZQINIT_NCK 1024
`define DDRSQ_ZQOPER_NCK 512
`define DDRSQ_ZQCS_NCK 128
`define DDRSQ_XPR_MIN_NCK 5
`define DDRSQ_XS_EXTRA_NS 10
`define DDRSQ_CKESR_EXTRA_NCK 1
`define DDRSQ_CKSRE_MIN_NCK 5
`define DDRSQ_CKSRE_NS 10
`define DDRSQ_RST_HOLD_NCK 16
`define DDRSQ_TRFC_NS 350
`define DDRSQ_TRFC4_NS 160
`define DDRSQ_TDLLK_NCK 768
`define DDRSQ_TCKE_NCK 4
`define DDRSQ_T_ALL 0
`define DDRSQ_T_NODLL 1
`define DDRSQ_T_FAST 2
`define DDRSQ_T_DLL 3
`define DDRSQ_T_NUM 4
`endif

// [ddrsq_pkg.sv]
// types and helper arithmetic of the ddr4 command sequencer
// assumes ddrsq_map.svh is on the include path
`include "ddrsq_map.svh"
`default_nettype none
package ddrsq_pkg;
    typedef enum logic [2:0] {
        op_nop, op_zq_long, op_zq_short, op_mrs_fast, op_plain, op_dll_rd, op_sre, op_srx
    } ddrsq_op_t;

    typedef enum logic [2:0] {
        st_rst_hold, st_zq_init, st_idle, st_sr_clk, st_sr_low, st_sr_wake
    } ddrsq_state_t;

    typedef struct packed {
        logic valid;
        ddrsq_op_t op;
    } ddrsq_cmd_t;

    typedef struct packed {
        logic par_en;
        logic abort_en;
        logic [`DDRSQ_PL_W-1:0] par_lat;
    } ddrsq_cfg_t;

    typedef struct packed {
        logic [`DDRSQ_CNT_W-1:0] cnt;
        logic busy;
    } ddrsq_tmr_t;

    typedef struct packed {
        ddrsq_state_t st;
        logic [`DDRSQ_CNT_W-1:0] cnt;
        logic [`DDRSQ_CNT_W-1:0] low;
        logic [`DDRSQ_CNT_W-1:0] gap;
        logic [`DDRSQ_CNT_W-1:0] since_srx;
        logic [`DDRSQ_CNT_W-1:0] since_rise;
        ddrsq_op_t last_op;
        logic cmd_init;
        logic prev_init;
        ddrsq_cmd_t cmd;
        logic ack;
        logic cke;
        logic rst_n;
        logic ck_en;
        logic done;
    } ddrsq_ctrl_t;

    // least time in ns to whole cycles, rounded up, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + `DDRSQ_CLK_PS - 1) / `DDRSQ_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic [`DDRSQ_CNT_W-1:0] inc_sat(input logic [`DDRSQ_CNT_W-1:0] x);
        return (&x) ? x : x + `DDRSQ_CNT_W'(1);
    endfunction
endpackage
`default_nettype wire

// [ddrsq_timer.sv]
// loadable down-counter that blocks one command class
// assumes load and value come from logic on the same clock
`timescale 1ns/1ps
`include "ddrsq_map.svh"
`default_nettype none
module ddrsq_timer
    import ddrsq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_load,
    input wire logic [`DDRSQ_CNT_W-1:0] i_val,
    output logic o_busy
);
    ddrsq_tmr_t r_reg;
    ddrsq_tmr_t r_next;

    // busy drops one edge early so a command may go out exactly on the last count
    always_comb begin
        r_next = r_reg;
        if (i_load) begin
            r_next.cnt = i_val; // R12
        end else if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - `DDRSQ_CNT_W'(1);
        end
        r_next.busy = (r_next.cnt > `DDRSQ_CNT_W'(1));
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_busy = r_reg.busy;

    chk_timer_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12
        i_load && i_val >= `DDRSQ_CNT_W'(3) |=> o_busy ##1 o_busy)
        else $error("timer released before its count ran out");
    chk_timer_short: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12
        !i_load && r_reg.cnt <= `DDRSQ_CNT_W'(2) |=> !o_busy)
        else $error("timer still blocking after its count ran out");
endmodule
`default_nettype wire

// [ddrsq_dram_model.sv]
// behavioural ddr4 device that judges command spacing and clock stop timing seen at its pins
// assumes every pin comes from registers on the same clock as the controller
`timescale 1ns/1ps
`default_nettype none
module ddrsq_dram_model
    import ddrsq_pkg::*;
#(
    parameter int XPR = 13,
    parameter int XS = 13,
    parameter int XS_FAST = 8,
    parameter int DLLK = 20,
    parameter int CKESR = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire ddrsq_cmd_t i_cmd,
    input wire logic i_cke,
    input wire logic i_ck_en,
    input wire ddrsq_cfg_t i_cfg,
    output logic [15:0] o_viol
);
    int blk;
    int since;
    int low;
    int age;
    int pl;
    logic cke_q;
    logic in_sr;
    logic zq_seen;
    // violations survive a device reset so the bench can read them at the end
    initial o_viol = '0;
    always_comb pl = i_cfg.par_en ? int'(i_cfg.par_lat) : 0;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            blk = 0;
            since = 0;
            in_sr = 1'b0;
            zq_seen = 1'b0;
            cke_q = 1'b0;
        end else begin
            if (in_sr && !i_cke) low++;
            if (in_sr) begin
                if (!i_ck_en && age < 5 + pl) o_viol++;
                age++;
            end
            if (i_cmd.valid) begin
                if (blk > 0) o_viol++;
                case (i_cmd.op)
                    op_plain: if (since > 0 && since < (i_cfg.abort_en ? XS_FAST : XS)) o_viol++;
                    op_zq_long, op_zq_short, op_mrs_fast: if (since > 0 && since < XS_FAST) o_viol++;
                    op_dll_rd: if (since > 0 && since < DLLK) o_viol++;
                    op_srx: if (!in_sr || low < CKESR + pl) o_viol++;
                    default: ;
                endcase
            end
            if (since > 0 && since < 100000) since++;
            if (blk > 0) blk--;
            if (i_cke && !cke_q && !in_sr) blk = XPR - 1;
            if (i_cmd.valid) begin
                case (i_cmd.op)
                    op_zq_long: blk = zq_seen ? 511 : 1023;
                    op_zq_short: blk = 127;
                    op_sre: begin
                        in_sr = 1'b1;
                        low = 1;
                        age = 1;
                    end
                    op_srx: begin
                        in_sr = 1'b0;
                        since = 1;
                    end
                    default: ;
                endcase
                if (i_cmd.op == op_zq_long) zq_seen = 1'b1;
            end
            cke_q = i_cke;
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the ddr4 reset, zq and self-refresh sequencer
// assumes the dram model counts every spacing violation it sees
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ddrsq_pkg::*;
    localparam int XPR = 13;  // 40 ns + 10 ns rounded up at 4 ns
    localparam int XS = 13;
    localparam int XF = 8;  // 20 ns + 10 ns rounded up at 4 ns
    localparam int DLLK = 20;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    ddrsq_cmd_t i_req = '0;
    ddrsq_cfg_t i_cfg = '0;
    logic o_ack, o_cke, o_dram_rst_n, o_ck_en, o_init_done;
    ddrsq_cmd_t o_cmd;
    logic [15:0] viol;
    logic [3:0] mon;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int last = 0;
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) cyc++;
    assign mon = {o_cmd.valid, o_ck_en, o_cke, o_ack};
    ddrsq_ctrl #(.TRFC_NS(40), .TRFC4_NS(20), .TDLLK_NCK(DLLK)) i_ddrsq_ctrl (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_cfg(i_cfg), .o_ack(o_ack),
        .o_cmd(o_cmd), .o_cke(o_cke), .o_dram_rst_n(o_dram_rst_n), .o_ck_en(o_ck_en),
        .o_init_done(o_init_done));
    ddrsq_dram_model #(.XPR(XPR), .XS(XS), .XS_FAST(XF), .DLLK(DLLK), .CKESR(5))
        i_ddrsq_dram_model (.i_clk(i_clk), .i_rst_n(o_dram_rst_n), .i_cmd(o_cmd),
        .i_cke(o_cke), .i_ck_en(o_ck_en), .i_cfg(i_cfg), .o_viol(viol));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    // bit k of mon: 0 ack, 1 cke, 2 clock enable, 3 command valid
    task automatic wait_for(input int k, input logic lvl, output int n);
        for (n = 1; n <= 3000; n++) begin
            tick();
            if (mon[k] === lvl) return;
        end
        check(32'h0, 32'h1);
        report_and_stop();
    endtask
    // one request; the gap runs from the previous command pulse to this one
    task automatic issue(input ddrsq_op_t op, input int gap, input int slack);
        int n;
        i_req = {1'b1, op};
        wait_for(0, 1'b1, n);
        i_req = '0;
        check(o_cmd, {1'b1, op});
        check((cyc - last >= gap) && (cyc - last <= gap + slack), 1'b1);
        last = cyc;
        tick();
    endtask
    task automatic init_seq();
        int n;
        wait_for(1, 1'b1, n);
        check(n, 17);
        check(o_dram_rst_n, 1'b1);
        wait_for(3, 1'b1, n);
        check(n, XPR);
        check(o_cmd, {1'b1, op_zq_long});
        check({o_init_done, o_ack}, 2'h2);
        last = cyc;
    endtask
    // enter self-refresh, leave it, then one command whose wait is judged
    task automatic sr_cycle(input ddrsq_op_t op, input int gap, input int pl);
        int n;
        issue(op_sre, 0, 5000);
        check(o_cke, 1'b0);
        wait_for(2, 1'b0, n);
        check(cyc - last, 5 + pl);
        issue(op_srx, 5 + pl, 100);
        check(o_cke, 1'b1);
        issue(op, gap, 2);
    endtask
    // a no-op request, then a wake-up outside self-refresh, must never be taken
    task automatic refuse_srx();
        int n;
        for (n = 0; n < 20; n++) begin
            i_req = {1'b1, (n < 10) ? op_nop : op_srx};
            tick();
            check(o_ack, 1'b0);
        end
        i_req = '0;
        tick();
    endtask
    initial begin
        repeat (10) tick();
        i_nrst = 1'b1;
        init_seq();
        issue(op_zq_short, 1024, 0);
        issue(op_zq_long, 128, 0);
        issue(op_plain, 512, 0);
        refuse_srx();
        sr_cycle(op_zq_short, XF, 0);
        sr_cycle(op_mrs_fast, XF, 0);
        sr_cycle(op_plain, XS, 0);
        sr_cycle(op_dll_rd, DLLK, 0);
        // second reset mid-run with parity and abort switched on
        i_nrst = 1'b0;
        i_cfg = {1'b1, 1'b1, 4'h3};
        repeat (10) tick();
        i_nrst = 1'b1;
        init_seq();
        issue(op_plain, 1024, 0);
        sr_cycle(op_plain, XF, 3);
        repeat (5) tick();
        check(viol, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
